// ==== design/rx_fifo_auto_flow_control.sv ====
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "afc_regs.svh"
// Overview of operation
// - High threshold bits 23:16, 64-byte units, triggers flow control.
// - Full duplex: one pause frame per high-threshold crossing, programmed pause time.
// - Half duplex: jam matching frames for the programmed duration after threshold.
// - Low threshold bits 15:8; falling below sends zero-time pause frame.
// - Zero-time pause only after high threshold caused a pause frame.
// - Duration code bits 7:4 sets jam time; unused in full duplex.
// - Bit 3 jams multicast frames past threshold; in full duplex only enables pause frames.
// - Bit 2 jams broadcast frames past threshold; in full duplex only enables pause frames.
// - Bit 1 jams own-address frames past threshold; in full duplex only enables pause frames.
// - Bit 0 acts on any frame, overrides bits 3:1.
// - Codes map 5 to 600 us at 100 Mb/s, plus 2.2 us at 10.
module rx_fifo_auto_flow_control #(
  parameter int LEVEL_W = 14
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  input  wire logic [LEVEL_W-1:0]   rx_fifo_bytes,
  input  wire afc_pkg::rx_frame_t   rx_frame,
  input  wire logic                 full_duplex,
  input  wire logic                 speed_10m,
  input  wire logic                 tx_enabled,
  input  wire logic                 pause_ack,
  output logic                      pause_req,
  output logic                      pause_zero,
  output logic                      jam
);
  localparam int JAM_CNT_W = 16;

  afc_pkg::auto_flow_settings_t   cfg_q;
  afc_pkg::auto_flow_settings_t   cfg_d;
  afc_pkg::afc_state_t state_q;
  afc_pkg::afc_state_t state_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  logic                req_q;
  logic                req_d;
  logic                zero_q;
  logic                zero_d;
  logic                jam_q;
  logic                jam_d;
  logic                was_above_q;
  logic                was_above_d;

  // Threshold in 64-byte units to a byte count
  function automatic logic [LEVEL_W+1:0] to_bytes(input logic [7:0] units);
    to_bytes = (LEVEL_W+2)'({units, 6'h00});
  endfunction

  // Register access
  wire               sel_cfg;
  wire               wr_cfg;
  wire               rd_cfg;
  wire [31:0]        cfg_word;
  // Level compare
  wire [LEVEL_W+1:0] level;
  wire [LEVEL_W+1:0] high_bytes;
  wire [LEVEL_W+1:0] low_bytes;
  wire               at_high;
  wire               below_low;
  wire               rise_high;
  // Frame match
  wire               enabled;
  wire               hit_mult;
  wire               hit_brd;
  wire               hit_own;
  wire               match;
  // Mode gating
  wire               half_active;
  wire               full_active;
  wire               jam_start;
  wire               jam_busy;

  assign sel_cfg     = (reg_addr == `AFC_SETTINGS_OFFSET);
  assign wr_cfg      = reg_wr && sel_cfg;
  assign rd_cfg      = reg_rd && sel_cfg;
  assign cfg_word    = {8'h00, cfg_q.high, cfg_q.low, cfg_q.dur,
                        cfg_q.mult, cfg_q.brd, cfg_q.own, cfg_q.any};
  assign cfg_d       = afc_pkg::auto_flow_settings_t'({reg_wdata[`FLOW_HIGH_THRESHOLD_MSB:`FLOW_HIGH_THRESHOLD_LSB],
                                            reg_wdata[`FLOW_LOW_THRESHOLD_MSB:`FLOW_LOW_THRESHOLD_LSB],
                                            reg_wdata[`AFC_DUR_MSB:`AFC_DUR_LSB],
                                            reg_wdata[`AFC_MULT_BIT],
                                            reg_wdata[`AFC_BRD_BIT],
                                            reg_wdata[`AFC_ADD_BIT],
                                            reg_wdata[`AFC_ANY_BIT]});
  assign rdata_d     = rd_cfg ? cfg_word : 32'h0000_0000;

  assign level       = (LEVEL_W+2)'(rx_fifo_bytes);
  assign high_bytes  = to_bytes(cfg_q.high);
  assign low_bytes   = to_bytes(cfg_q.low);
  assign at_high     = (level >= high_bytes);
  assign below_low   = (level < low_bytes);
  assign rise_high   = at_high && !was_above_q;
  assign was_above_d = at_high;

  assign enabled     = cfg_q.any | cfg_q.mult | cfg_q.brd | cfg_q.own;
  assign hit_mult    = cfg_q.mult && rx_frame.is_multicast;
  assign hit_brd     = cfg_q.brd && rx_frame.is_broadcast;
  assign hit_own     = cfg_q.own && rx_frame.is_own_addr;
  assign match       = cfg_q.any || hit_mult || hit_brd || hit_own;

  assign half_active = tx_enabled && !full_duplex;
  assign full_active = tx_enabled && full_duplex;
  assign jam_start   = half_active && at_high && rx_frame.start && match;
  assign jam_d       = (jam_busy || jam_start) && half_active;

  // Back-pressure timer, restarted by each matching frame past the high threshold
  jam_timer #(
    .CNT_W (JAM_CNT_W)
  ) u_jam_timer (
    .clk   (clk),
    .rst   (rst),
    .start (jam_start),
    .code  (cfg_q.dur),
    .slow  (speed_10m),
    .busy  (jam_busy)
  );

  always_comb begin
    state_d = state_q;
    req_d   = req_q && !pause_ack;
    zero_d  = zero_q && !pause_ack;
    case (state_q)
      afc_pkg::ST_IDLE: begin
        // Timed pause once per crossing
        if (full_active && enabled && rise_high && !req_q) begin
          req_d   = 1'b1;
          zero_d  = 1'b0;
          state_d = afc_pkg::ST_PAUSED;
        end
      end
      afc_pkg::ST_PAUSED: begin
        // Zero pause only after a timed one
        if (below_low && enabled && tx_enabled && !req_q) begin
          req_d   = 1'b1;
          zero_d  = 1'b1;
          state_d = afc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = afc_pkg::ST_IDLE;
      end
    endcase
  end

  // Settings register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= afc_pkg::auto_flow_settings_t'(24'(`AFC_SETTINGS_RESET));
    end else if (wr_cfg) begin
      cfg_q <= cfg_d;
    end
  end

  // Read data stands one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pause sequencing state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= afc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Pause request, held until taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end

  // Zero-time flag travels with the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= zero_d;
    end
  end

  // Back pressure output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jam_q <= 1'b0;
    end else begin
      jam_q <= jam_d;
    end
  end

  // Previous threshold state for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      was_above_q <= 1'b0;
    end else begin
      was_above_q <= was_above_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign pause_req  = req_q;
  assign pause_zero = zero_q;
  assign jam        = jam_q;
endmodule

// ==== design/afc_regs.svh ====
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH
`define AFC_SETTINGS_OFFSET   8'hAC
`define FLOW_HIGH_THRESHOLD_MSB            23
`define FLOW_HIGH_THRESHOLD_LSB            16
`define FLOW_LOW_THRESHOLD_MSB            15
`define FLOW_LOW_THRESHOLD_LSB            8
`define AFC_DUR_MSB           7
`define AFC_DUR_LSB           4
`define AFC_MULT_BIT          3
`define AFC_BRD_BIT           2
`define AFC_ADD_BIT           1
`define AFC_ANY_BIT           0
`define AFC_SETTINGS_RESET    32'h0000_0000
`define AFC_UNIT_SHIFT        6
`define AFC_CLK_MHZ           40
`define AFC_TICK_NS           100
`define AFC_TICK_CYCLES       ((`AFC_TICK_NS * `AFC_CLK_MHZ) / 1000)
`define AFC_SLOW_EXTRA_NS     2200
`define AFC_SLOW_EXTRA_CYCLES ((`AFC_SLOW_EXTRA_NS * `AFC_CLK_MHZ) / 1000)
`endif

// ==== design/afc_pkg.sv ====
package afc_pkg;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [3:0] dur;
    logic       mult;
    logic       brd;
    logic       own;
    logic       any;
  } auto_flow_settings_t;

  typedef struct packed {
    logic start;
    logic is_multicast;
    logic is_broadcast;
    logic is_own_addr;
  } rx_frame_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PAUSED} afc_state_t;
endpackage

// ==== design/jam_timer.sv ====
`timescale 1ns/1ps
`include "afc_regs.svh"
module jam_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [3:0] code,
  input  wire logic       slow,
  output logic            busy
);
  // Duration in 100 ns ticks, 100 Mb/s figures
  function automatic logic [12:0] dur_ticks(input logic [3:0] c);
    case (c)
      4'h0:    dur_ticks = 13'h0032;
      4'h1:    dur_ticks = 13'h0064;
      4'h2:    dur_ticks = 13'h0096;
      4'h3:    dur_ticks = 13'h00FA;
      default: dur_ticks = 13'(({9'h000, c} - 13'h0003) * 13'h01F4);
    endcase
  endfunction

  logic [CNT_W-1:0] ticks_q;
  logic [7:0]       pre_q;
  logic             tick;
  logic [12:0]      extra;
  logic [CNT_W-1:0] load;

  assign tick  = (pre_q == 8'(`AFC_TICK_CYCLES - 1));
  assign extra = slow ? 13'(`AFC_SLOW_EXTRA_NS / `AFC_TICK_NS) : 13'h0000;
  assign load  = CNT_W'(dur_ticks(code) + extra);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q   <= 8'h00;
      ticks_q <= '0;
    end else if (start) begin
      pre_q   <= 8'h00;
      ticks_q <= load;
    end else if (ticks_q != '0) begin
      pre_q <= tick ? 8'h00 : pre_q + 8'h01;
      if (tick) ticks_q <= ticks_q - CNT_W'(1);
    end
  end

  assign busy = (ticks_q != '0);
endmodule

// ==== tb/mac_tx_model.sv ====
`timescale 1ns/1ps
module mac_tx_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pause_req,
  output logic      pause_ack
);
  logic [1:0] wait_q;
  // Slow transmitter: takes a request after a queueing delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q    <= 2'h0;
      pause_ack <= 1'b0;
    end else begin
      pause_ack <= pause_req && !pause_ack && wait_q == 2'h3;
      wait_q    <= (pause_req && !pause_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// ==== tb/afc_assertions.sv ====
`timescale 1ns/1ps
module afc_assertions (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire afc_pkg::rx_frame_t rx_frame,
  input wire logic               full_duplex,
  input wire logic               tx_enabled,
  input wire logic               pause_ack,
  input wire logic               pause_req,
  input wire logic               pause_zero,
  input wire logic               jam
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic armed_q;
  // Set when a timed pause is taken, cleared by its zero pause
  always_ff @(posedge clk or posedge rst) begin
    if (rst) armed_q <= 1'b0;
    else if (pause_req && pause_ack) armed_q <= !pause_zero;
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");
  rdata_top_a: assert property (reg_rdata[31:24] == 8'h00) else $error("rdata top bits");
  req_hold_a: assert property (pause_req && !pause_ack |=> pause_req) else $error("req dropped");
  req_drop_a: assert property (pause_ack |=> !pause_req) else $error("req held");
  pause_cause_a: assert property ($rose(pause_req) |-> $past(full_duplex) && $past(tx_enabled))
    else $error("pause cause");
  zero_order_a: assert property ($rose(pause_req) |-> pause_zero == armed_q) else $error("pause order");
  zero_with_req_a: assert property (pause_zero |-> pause_req) else $error("zero alone");
  jam_cause_a: assert property ($rose(jam) |-> $past(rx_frame.start) && !$past(full_duplex))
    else $error("jam cause");
  jam_off_a: assert property ((!tx_enabled || full_duplex) [*2] |-> !jam) else $error("jam forced");
endmodule
bind rx_fifo_auto_flow_control afc_assertions chk_u (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_frame(rx_frame), .full_duplex(full_duplex), .tx_enabled(tx_enabled), .pause_ack(pause_ack),
  .pause_req(pause_req), .pause_zero(pause_zero), .jam(jam));

// ==== tb/rx_fifo_auto_flow_control_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("mismatch t=%0t %h %h", $time, a, b); end end
module rx_fifo_auto_flow_control_tb_top;
  logic               clk, rst, reg_wr, reg_rd, full_duplex, speed_10m, tx_enabled, pause_ack, pause_req, pause_zero, jam;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata;
  logic [13:0]        rx_fifo_bytes;
  afc_pkg::rx_frame_t rx_frame;
  int                 errors = 0, total_checks = 0, cycles = 0, n;
  rx_fifo_auto_flow_control dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_fifo_bytes(rx_fifo_bytes), .rx_frame(rx_frame), .full_duplex(full_duplex),
    .speed_10m(speed_10m), .tx_enabled(tx_enabled), .pause_ack(pause_ack), .pause_req(pause_req),
    .pause_zero(pause_zero), .jam(jam));
  mac_tx_model tx_u (.clk(clk), .rst(rst), .pause_req(pause_req), .pause_ack(pause_ack));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [31:0] d);
    reg_addr <= 8'hAC;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
    @(posedge clk);
  endtask
  task automatic lvl(input logic [13:0] v, input logic r, input logic z);
    rx_fifo_bytes <= v;
    @(posedge clk);
    #1 `CHK({pause_req, pause_zero}, {r, z})
    repeat (12) @(posedge clk);
  endtask
  task automatic frame(input logic [2:0] f, input int len);
    rx_frame <= {1'b1, f};
    @(posedge clk);
    rx_frame <= 4'h0;
    n = 0;
    #1 while (jam === 1'b1 && n < 1000) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n inside {[len:len + (len ? 4 : 0)]}, 1'b1)
    @(posedge clk);
  endtask
  initial begin
    {rst, reg_addr, reg_wdata, reg_wr, reg_rd, rx_fifo_bytes, rx_frame, speed_10m} = {1'b1, 61'h0};
    {full_duplex, tx_enabled} = 2'h3;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'hAC, 32'h0);
    wr(32'hFF04_0201);
    rd(8'hAC, 32'h0004_0201);
    rd(8'h10, 32'h0);
    lvl(14'h064, 1'b0, 1'b0);
    lvl(14'h0FF, 1'b0, 1'b0);
    lvl(14'h100, 1'b1, 1'b0);
    lvl(14'h12C, 1'b0, 1'b0);
    lvl(14'h080, 1'b0, 1'b0);
    lvl(14'h07F, 1'b1, 1'b1);
    tx_enabled <= 1'b0;
    lvl(14'h100, 1'b0, 1'b0);
    frame(3'h0, 0);
    full_duplex <= 1'b0;
    tx_enabled <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(32'h0004_0200 | (32'h8 >> i));
      frame(3'h4 >> i, 200);
      if (i < 3) frame((i == 2) ? 3'h4 : (3'h4 >> (i + 1)), 0);
    end
    wr(32'h0004_0211);
    speed_10m <= 1'b1;
    frame(3'h0, 488);
    lvl(14'h0FF, 1'b0, 1'b0);
    frame(3'h7, 0);
    end_of_test();
  end
endmodule
